// ===== pkg/pac_cfg.svh
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH

// ****************************************
// frame layout
// ****************************************
`define PAC_FRAME_LAST   4'h8
`define PAC_IDX_ADDR     4'h0
`define PAC_IDX_OP       4'h1
`define PAC_IDX_TYPE     4'h2
`define PAC_IDX_BANK     4'h3
`define PAC_IDX_V3       4'h4
`define PAC_IDX_V2       4'h5
`define PAC_IDX_V1       4'h6
`define PAC_IDX_V0       4'h7
`define PAC_IDX_SUM      4'h8

// ****************************************
// instruction codes
// ****************************************
`define PAC_OP_AXIS_WRITE   8'h05
`define PAC_OP_AXIS_READ    8'h06
`define PAC_OP_AXIS_STORE   8'h07
`define PAC_OP_AXIS_RESTORE 8'h08
`define PAC_OP_GLOB_WRITE   8'h09
`define PAC_OP_GLOB_READ    8'h0a

// ****************************************
// reply status codes
// ****************************************
`define PAC_ST_OK        8'h64
`define PAC_ST_BAD_SUM   8'h01
`define PAC_ST_BAD_OP    8'h02
`define PAC_ST_BAD_TYPE  8'h03
`define PAC_ST_BAD_VALUE 8'h04

// ****************************************
// banks and parameter numbers
// ****************************************
`define PAC_BANK_MODULE  8'h00
`define PAC_BANK_USER    8'h02
`define PAC_BANK_IRQ     8'h03
`define PAC_MOTOR0       8'h00
`define PAC_AXIS_ACTPOS  8'h01
`define PAC_GLOB_SERADDR 8'h42
`define PAC_NPAR         16
`define PAC_PAR_LIMIT    8'h10
`define PAC_IDX_END      4'hf
`define PAC_ADDR_RST     8'h01

// ****************************************
// register bus map and answers
// ****************************************
`define PAC_REG_CTRL     8'h00
`define PAC_REG_ACCU     8'h04
`define PAC_REG_STATUS   8'h08
`define PAC_REG_VALUE    8'h0c
`define PAC_RESP_OKAY    2'h0
`define PAC_RESP_SLVERR  2'h2

`endif

// ===== pkg/pac_pkg.sv
`include "pac_cfg.svh"

package pac_pkg;

    typedef enum logic [1:0] {
        PAC_RESTORE,
        PAC_IDLE,
        PAC_EXEC,
        PAC_REPLY
    } pac_state_e;

    typedef logic [`PAC_NPAR-1:0][31:0] pac_bank_t;

    typedef struct packed {
        pac_state_e       state;
        logic [3:0]       idx;
        logic [3:0]       cnt;
        logic [8:0][7:0]  frame;
        pac_bank_t        axis_work;
        pac_bank_t        axis_nv;
        pac_bank_t        glob_mod;
        pac_bank_t        glob_mod_nv;
        pac_bank_t        glob_user;
        pac_bank_t        glob_irq;
        logic [7:0]       addr;
        logic [7:0]       addr_nv;
        logic [31:0]      accu;
        logic             standalone;
        logic [7:0]       rpl_status;
        logic [7:0]       rpl_instr;
        logic [31:0]      rpl_value;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } pac_state_s;

endpackage

// ===== test/pac_core_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "pac_cfg.svh"

module pac_core_chk (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    input  wire logic        rx_ready,
    input  wire logic [31:0] actual_pos,
    input  wire logic        rpl_valid,
    input  wire logic        rpl_ready,
    input  wire logic [7:0]  rpl_status,
    input  wire logic [7:0]  rpl_instr,
    input  wire logic [31:0] rpl_value
);
    // ****************
    // frame tracking
    // ****************
    logic [3:0]      cnt;
    logic [8:0][7:0] fb;
    logic [7:0]      sum;
    logic            took;
    logic            last;

    assign took = rx_valid && rx_ready && clk_en;
    assign last = took && cnt == 4'h8;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cnt <= 4'h0;
        end else if (took) begin
            fb[cnt] <= rx_data;
            cnt     <= last ? 4'h0 : cnt + 4'h1;
        end
    end

    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + fb[i];
        end
    end

    // ****************
    // properties
    // ****************
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence reply_start;
        $rose(rpl_valid);
    endsequence

    sequence ok_reply(op);
        $rose(rpl_valid) ##0 (rpl_status == `PAC_ST_OK && rpl_instr == op);
    endsequence

    a_reply_latency: assert property (reply_start |-> $past(last, 2))
        else $error("reply not two cycles after last byte");
    a_reply_stands: assert property (rpl_valid && !rpl_ready |=>
        rpl_valid && $stable(rpl_value) && $stable(rpl_status))
        else $error("reply changed before it was taken");
    a_rx_closed: assert property (rpl_valid |-> !rx_ready)
        else $error("byte accepted while reply pending");
    a_store_zero: assert property (reply_start ##0
        (rpl_status == `PAC_ST_OK && rpl_instr inside {8'h07, 8'h08})
        |-> rpl_value == 32'h0)
        else $error("store or restore reply value not zero");
    a_actpos_read: assert property (ok_reply(8'h06) ##0
        (fb[2] == `PAC_AXIS_ACTPOS && fb[3] == `PAC_MOTOR0)
        |-> rpl_value == $past(actual_pos))
        else $error("position read does not return position");
    a_sum_reject: assert property (reply_start ##0 (fb[8] != sum)
        |-> rpl_status == `PAC_ST_BAD_SUM && rpl_value == 32'h0)
        else $error("bad checksum not rejected");
    a_glob_echo: assert property (ok_reply(8'h09)
        |-> rpl_value == {fb[4], fb[5], fb[6], fb[7]})
        else $error("global write reply value wrong");
    a_bank_check: assert property (reply_start ##0
        (rpl_instr inside {8'h09, 8'h0a} && fb[8] == sum
        && fb[2] < `PAC_PAR_LIMIT && !(fb[3] inside {8'h00, 8'h02, 8'h03}))
        |-> rpl_status == `PAC_ST_BAD_VALUE)
        else $error("unused bank accepted");
    a_restore_hold: assert property ($rose(rstn) |-> !rx_ready [*8])
        else $error("commands accepted before restore");
endmodule

bind pac_core pac_core_chk u_chk (
    .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .actual_pos(actual_pos), .rpl_valid(rpl_valid),
    .rpl_ready(rpl_ready), .rpl_status(rpl_status),
    .rpl_instr(rpl_instr), .rpl_value(rpl_value)
);

`default_nettype wire

// ===== test/pac_core_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "pac_cfg.svh"

module pac_core_test;
    logic        sys_clk, rstn, clk_en, rx_valid, rx_ready, got;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rpl_valid, rpl_ready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, rpl_status;
    logic [7:0]  rpl_instr, maddr, t, b, st;
    logic [31:0] s_axi_wdata, s_axi_rdata, actual_pos, rpl_value;
    logic [31:0] v1, d, vo;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    integer      seed;
    int          failures, compares, i;

    pac_core dut (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .actual_pos(actual_pos),
        .rpl_valid(rpl_valid), .rpl_ready(rpl_ready),
        .rpl_status(rpl_status), .rpl_instr(rpl_instr),
        .rpl_value(rpl_value)
    );

    pac_host_model host (
        .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rpl_ready(rpl_ready), .rpl_valid(rpl_valid),
        .rpl_status(rpl_status), .rpl_value(rpl_value)
    );

    always #50 sys_clk = ~sys_clk;

    // ****************
    // helpers
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] exp_st(input logic [7:0] op, ty, bk);
        if (op < 8'h05 || op > 8'h0a) return `PAC_ST_BAD_OP;
        if (ty >= `PAC_PAR_LIMIT && !(op > 8'h08
            && ty == `PAC_GLOB_SERADDR && bk == 8'h00))
            return `PAC_ST_BAD_TYPE;
        if (op < 8'h09 ? bk != 8'h00 : !(bk inside {8'h00, 8'h02, 8'h03}))
            return `PAC_ST_BAD_VALUE;
        return `PAC_ST_OK;
    endfunction

    function automatic logic flag(input int k);
        return k == 0 ? s_axi_awready && s_axi_wready : k == 1 ? s_axi_bvalid
            : k == 2 ? s_axi_arready : s_axi_rvalid;
    endfunction

    task automatic wait_hi(input int k);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (!flag(k) && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        if (!flag(k)) failures++;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dv);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= dv;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        wait_hi(0);
        @(posedge sys_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        s_axi_bready  <= 1'b1;
        wait_hi(1);
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        wait_hi(2);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        wait_hi(3);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask

    // an expected value of all x skips the value compare
    task automatic cmd(input logic [7:0] op, ty, bk, input logic [31:0] v,
                       input logic [31:0] ev, input bit bad);
        host.xfer({maddr, op, ty, bk, v}, bad, $random(seed) & 3, st, vo, got);
        check(32'(got), 32'h1);
        check(32'(st), 32'(bad ? `PAC_ST_BAD_SUM : exp_st(op, ty, bk)));
        if (ev !== 32'hx) check(vo, ev);
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
    endtask

    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    initial begin
        seed = 43256;
        sys_clk = 1'b0;
        clk_en = 1'b1;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, actual_pos} = '0;
        maddr = `PAC_ADDR_RST;
        do_reset();
        for (i = 0; i < 4; i++) begin
            t  = 8'h02 + 8'($random(seed) & 7);
            v1 = $random(seed);
            cmd(8'h05, t, 8'h00, v1, 32'hx, 0);
            cmd(8'h06, t, 8'h00, 32'h0, v1, 0);
            cmd(8'h07, t, 8'h00, ~v1, 32'h0, 0);
            cmd(8'h05, t, 8'h00, ~v1, 32'hx, 0);
            cmd(8'h08, t, 8'h00, ~v1, 32'h0, 0);
            cmd(8'h06, t, 8'h00, 32'h0, v1, 0);
        end
        cmd(8'h07, t, 8'h01, 32'h0, 32'h0, 0);
        $display("axis store and restore done");
        actual_pos <= $random(seed);
        @(posedge sys_clk);
        cmd(8'h06, `PAC_AXIS_ACTPOS, 8'h00, 32'h0, actual_pos, 0);
        axi_wr(`PAC_REG_CTRL, 32'h0);
        axi_wr(`PAC_REG_ACCU, 32'h5a5a_0f0f);
        cmd(8'h06, t, 8'h00, 32'h0, v1, 0);
        axi_rd(`PAC_REG_ACCU);
        check(d, 32'h5a5a_0f0f);
        axi_wr(`PAC_REG_CTRL, 32'h1);
        cmd(8'h06, t, 8'h00, 32'h0, v1, 0);
        axi_rd(`PAC_REG_ACCU);
        check(d, v1);
        axi_rd(8'h10);
        check(d | 32'(r), 32'(`PAC_RESP_SLVERR));
        $display("accumulator done");
        for (i = 0; i < 8; i++) begin
            b  = 8'(i % 4);
            t  = 8'($random(seed) & 15);
            v1 = $random(seed);
            cmd(8'h09, t, b, v1, v1, 0);
            cmd(8'h0a, t, b, ~v1, b == 8'h01 ? 32'h0 : v1, 0);
            axi_rd(`PAC_REG_ACCU);
            if (b != 8'h01) check(d, v1);
        end
        cmd(8'h0a, 8'h00, 8'h02, 32'h0, 32'h0, 1);
        cmd(8'h03, 8'h00, 8'h00, 32'h0, 32'h0, 0);
        $display("global parameters done");
        cmd(8'h09, `PAC_GLOB_SERADDR, 8'h00, 32'h3, 32'h3, 0);
        host.xfer({8'h01, 8'h0a, `PAC_GLOB_SERADDR, 40'h0}, 0, 0, st, vo, got);
        check(32'(got), 32'h0);
        maddr = 8'h03;
        cmd(8'h0a, `PAC_GLOB_SERADDR, 8'h00, 32'h0, 32'h3, 0);
        axi_rd(`PAC_REG_STATUS);
        check(32'(d[23:16]), 32'h3);
        $display("serial address done");
        do_reset();
        maddr = `PAC_ADDR_RST;
        cmd(8'h06, 8'h05, 8'h00, 32'h0, 32'h0, 0);
        $display("restore after reset done");
        wrap_up();
    end

    // about fifty frames of some twelve cycles each, over twentyfold margin
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
endmodule

`default_nettype wire

// ===== test/pac_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module pac_host_model (
    input  wire logic        sys_clk,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic             rpl_ready,
    input  wire logic        rpl_valid,
    input  wire logic [7:0]  rpl_status,
    input  wire logic [31:0] rpl_value
);
    // ****************
    // frame sender
    // ****************
    initial begin
        rx_data   = 8'h00;
        rx_valid  = 1'b0;
        rpl_ready = 1'b0;
    end

    // f8 holds address, op, type, bank and value, first byte on top
    task automatic xfer(input logic [63:0] f8, input bit bad,
                        input int stall, output logic [7:0] st,
                        output logic [31:0] vo, output bit got);
        logic [71:0] f;
        logic [7:0]  s;
        int          n;
        begin
            s = 8'h00;
            for (int i = 0; i < 8; i++) begin
                s = s + f8[63-8*i -: 8];
            end
            f = {f8, bad ? ~s : s};
            for (int i = 0; i < 9; i++) begin
                rx_data  <= f[71-8*i -: 8];
                rx_valid <= 1'b1;
                n = 0;
                @(negedge sys_clk);
                while (!rx_ready && n < 99) begin
                    @(negedge sys_clk);
                    n++;
                end
                @(posedge sys_clk);
            end
            rx_valid <= 1'b0;
            // released line shows the inverse, never a stale byte
            rx_data  <= ~f[7:0];
            repeat (stall) @(posedge sys_clk);
            rpl_ready <= 1'b1;
            n = 0;
            @(negedge sys_clk);
            while (!rpl_valid && n < 20) begin
                @(negedge sys_clk);
                n++;
            end
            got = rpl_valid;
            st  = rpl_status;
            vo  = rpl_value;
            @(posedge sys_clk);
            rpl_ready <= 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ===== verilog/pac_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "pac_cfg.svh"

module pac_core (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [31:0] actual_pos,
    output logic             rpl_valid,
    input  wire logic        rpl_ready,
    output logic [7:0]       rpl_status,
    output logic [7:0]       rpl_instr,
    output logic [31:0]      rpl_value
);
    import pac_pkg::*;

    pac_state_s s;
    pac_state_s next_s;

    logic [7:0]  sum;
    logic [7:0]  op;
    logic [7:0]  ptype;
    logic [7:0]  bank;
    logic [31:0] value;
    logic [3:0]  pidx;
    logic        in_range;
    logic        wr_go;
    logic        rd_go;
    logic        rx_take;

    // ****************************************
    // handshakes
    // ****************************************
    // no command bytes are taken while the restore walk runs
    assign rx_ready      = (s.state == PAC_IDLE) & clk_en;
    assign rx_take       = rx_valid & rx_ready & clk_en;
    assign rpl_valid     = (s.state == PAC_REPLY);
    assign rpl_status    = s.rpl_status;
    assign rpl_instr     = s.rpl_instr;
    assign rpl_value     = s.rpl_value;
    // address and data are taken together, one write in flight
    assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s.bvalid & clk_en;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign rd_go         = s_axi_arvalid & ~s.rvalid & clk_en;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = s.rdata;
    assign s_axi_rresp   = s.rresp;

    // ****************************************
    // frame fields
    // ****************************************
    assign op       = s.frame[`PAC_IDX_OP];
    assign ptype    = s.frame[`PAC_IDX_TYPE];
    assign bank     = s.frame[`PAC_IDX_BANK];
    assign value    = {s.frame[`PAC_IDX_V3], s.frame[`PAC_IDX_V2],
                       s.frame[`PAC_IDX_V1], s.frame[`PAC_IDX_V0]};
    assign pidx     = ptype[3:0];
    assign in_range = (ptype < `PAC_PAR_LIMIT);

    always_comb begin
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + s.frame[i];
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_s = s;
        unique case (s.state)
            PAC_RESTORE: begin
                next_s.axis_work[s.idx] = s.axis_nv[s.idx];
                next_s.glob_mod[s.idx]  = s.glob_mod_nv[s.idx];
                next_s.addr             = s.addr_nv;
                next_s.idx              = s.idx + 4'h1;
                if (s.idx == `PAC_IDX_END) begin
                    next_s.state = PAC_IDLE;
                end
            end
            PAC_IDLE: begin
                if (rx_take) begin
                    next_s.frame[s.cnt] = rx_data;
                    next_s.cnt          = s.cnt + 4'h1;
                    if (s.cnt == `PAC_FRAME_LAST) begin
                        next_s.cnt   = 4'h0;
                        next_s.state = PAC_EXEC;
                    end
                end
            end
            PAC_EXEC: begin
                next_s.state      = PAC_REPLY;
                next_s.rpl_instr  = op;
                next_s.rpl_status = `PAC_ST_OK;
                next_s.rpl_value  = 32'h0000_0000;
                if (s.frame[`PAC_IDX_ADDR] != s.addr) begin
                    // frames for other modules on the bus get no answer
                    next_s.state = PAC_IDLE;
                end else if (sum != s.frame[`PAC_IDX_SUM]) begin
                    next_s.rpl_status = `PAC_ST_BAD_SUM;
                end else begin
                    unique case (op)
                        `PAC_OP_AXIS_WRITE,
                        `PAC_OP_AXIS_READ,
                        `PAC_OP_AXIS_STORE,
                        `PAC_OP_AXIS_RESTORE: begin
                            if (bank != `PAC_MOTOR0) begin
                                next_s.rpl_status = `PAC_ST_BAD_VALUE;
                            end else if (!in_range) begin
                                next_s.rpl_status = `PAC_ST_BAD_TYPE;
                            end else if (op == `PAC_OP_AXIS_WRITE) begin
                                next_s.axis_work[pidx] = value;
                            end else if (op == `PAC_OP_AXIS_READ) begin
                                // position comes live from the motion side
                                next_s.rpl_value =
                                    (ptype == `PAC_AXIS_ACTPOS) ?
                                    actual_pos : s.axis_work[pidx];
                                if (s.standalone) begin
                                    next_s.accu = next_s.rpl_value;
                                end
                            end else if (op == `PAC_OP_AXIS_STORE) begin
                                next_s.axis_nv[pidx] = s.axis_work[pidx];
                            end else begin
                                next_s.axis_work[pidx] = s.axis_nv[pidx];
                            end
                        end
                        `PAC_OP_GLOB_WRITE: begin
                            next_s.rpl_value = value;
                            unique case (bank)
                                `PAC_BANK_MODULE: begin
                                    if (ptype == `PAC_GLOB_SERADDR) begin
                                        next_s.addr    = value[7:0];
                                        next_s.addr_nv = value[7:0];
                                    end else if (in_range) begin
                                        next_s.glob_mod[pidx]    = value;
                                        next_s.glob_mod_nv[pidx] = value;
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                `PAC_BANK_USER: begin
                                    if (in_range) begin
                                        next_s.glob_user[pidx] = value;
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                `PAC_BANK_IRQ: begin
                                    if (in_range) begin
                                        next_s.glob_irq[pidx] = value;
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                default: begin
                                    next_s.rpl_status = `PAC_ST_BAD_VALUE;
                                end
                            endcase
                        end
                        `PAC_OP_GLOB_READ: begin
                            unique case (bank)
                                `PAC_BANK_MODULE: begin
                                    if (ptype == `PAC_GLOB_SERADDR) begin
                                        next_s.rpl_value = {24'h00_0000,
                                                            s.addr};
                                    end else if (in_range) begin
                                        next_s.rpl_value = s.glob_mod[pidx];
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                `PAC_BANK_USER: begin
                                    if (in_range) begin
                                        next_s.rpl_value = s.glob_user[pidx];
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                `PAC_BANK_IRQ: begin
                                    if (in_range) begin
                                        next_s.rpl_value = s.glob_irq[pidx];
                                    end else begin
                                        next_s.rpl_status = `PAC_ST_BAD_TYPE;
                                    end
                                end
                                default: begin
                                    next_s.rpl_status = `PAC_ST_BAD_VALUE;
                                end
                            endcase
                            if (next_s.rpl_status == `PAC_ST_OK) begin
                                next_s.accu = next_s.rpl_value;
                            end
                        end
                        default: begin
                            next_s.rpl_status = `PAC_ST_BAD_OP;
                        end
                    endcase
                end
            end
            PAC_REPLY: begin
                if (rpl_ready) begin
                    next_s.state = PAC_IDLE;
                end
            end
        endcase

        // ****************************************
        // register bus
        // ****************************************
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp  = `PAC_RESP_OKAY;
            if (s_axi_awaddr == `PAC_REG_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    next_s.standalone = s_axi_wdata[0];
                end
            end else if (s_axi_awaddr == `PAC_REG_ACCU) begin
                // a command executing in the same cycle wins: the bus write to accu is dropped
                if (s.state != PAC_EXEC) begin
                    for (int b = 0; b < 4; b++) begin
                        if (s_axi_wstrb[b]) begin
                            next_s.accu[b*8 +: 8] = s_axi_wdata[b*8 +: 8];
                        end
                    end
                end
            end else if (s_axi_awaddr != `PAC_REG_STATUS &&
                         s_axi_awaddr != `PAC_REG_VALUE) begin
                next_s.bresp = `PAC_RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `PAC_RESP_OKAY;
            unique case (s_axi_araddr)
                `PAC_REG_CTRL:   next_s.rdata = {31'h0000_0000, s.standalone};
                `PAC_REG_ACCU:   next_s.rdata = s.accu;
                `PAC_REG_STATUS: next_s.rdata = {7'h00,
                                                 s.state == PAC_RESTORE,
                                                 s.addr, s.rpl_instr,
                                                 s.rpl_status};
                `PAC_REG_VALUE:  next_s.rdata = s.rpl_value;
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = `PAC_RESP_SLVERR;
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // the stored copies are cleared too, but addr_nv takes PAC_ADDR_RST: there is no real memory behind
    // them here, so a reset stands in for a blank part
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s         <= '0;
            s.state   <= PAC_RESTORE;
            s.addr    <= `PAC_ADDR_RST;
            s.addr_nv <= `PAC_ADDR_RST;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire
